// ===== hw/cdc_regs.vh
// Purpose: Constants for the calibration converter control block.
// Assumes: Register word is 24 bits wide at address 0x09.
// Notes:   Chop rate derived from the 10 MHz reference clock.
`ifndef CDC_REGS_VH
`define CDC_REGS_VH
`define CDC_ADDR          8'h09
`define CDC_RESET         24'h002000
`define CDC_BIT_CHOP      13
`define CDC_BIT_MODE      12
`define CDC_BIT_INT       11
`define CDC_BIT_EN        10
`define CDC_CODE_MSB      9
`define CDC_CODE_W        10
`define CDC_CLK_HZ        10000000
`define CDC_CHOP_HZ       256000
// Half-period of the chop clock in reference cycles, rounded down.
`define CDC_CHOP_HALF     (`CDC_CLK_HZ / (2 * `CDC_CHOP_HZ))
`define CDC_EXTRA_SCLK    4
`endif

// ===== hw/cdc_chop_div.v
// Purpose: Divider giving a one-cycle enable at twice the chop rate.
// Assumes: Count fits in eight bits.
// Notes:   Held clear while chopping is off.
`timescale 1ns/100ps
`include "cdc_regs.vh"
module cdc_chop_div (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       run,
  output reg        tick
);
  localparam integer LAST_I = `CDC_CHOP_HALF - 1;
  localparam [7:0]   LAST   = LAST_I[7:0];
  reg [7:0] count_r;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 8'h00;
      tick    <= 1'b0;
    end else if (!run) begin
      count_r <= 8'h00;
      tick    <= 1'b0;
    end else if (count_r == LAST) begin
      count_r <= 8'h00;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule

// ===== hw/cdc_calibration_dac_control.v
// What this block does
// - Bit 13 chops converter output at 256 kHz
// - Bit 12 connects pin, starts channel acquisition
// - Bit 11 one in calibration mode (bit 12 set): open switches, route internally
// - Bit 10 enables converter; zero keeps off
// - Master with bit 10 set outside calibration mode drives pin
// - Slave keeps converter off despite enable
// - Converter enabled disables ac lead-off detection
// - Bits 9:0 hold converter code, reset zero
//
// Purpose: Holds the calibration converter register and drives controls.
// Assumes: Serial decode elsewhere supplies word writes in this domain.
// Notes:   A written word takes effect after the extra serial clocks.
`timescale 1ns/100ps
`include "cdc_regs.vh"
module cdc_calibration_dac_control (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        regWrite,
  input  wire [7:0]  regAddr,
  input  wire [23:0] regWdata,
  input  wire        sclkEdge,
  input  wire        slaveMode,
  output reg  [23:0] regRdata,
  output reg         converterOn,
  output reg  [9:0]  converterCode,
  output reg         chopPhase,
  output reg         calPinConnect,
  output reg         channelAcquire,
  output reg         extSwitchOpen,
  output reg         internalRoute,
  output reg         acLeadOffDisable
);
  reg  [23:0] pend_r;
  reg  [2:0]  sclkCnt_r;
  reg         pendValid_r;
  reg         chop_r;
  reg         mode_r;
  reg         int_r;
  reg         en_r;
  reg  [9:0]  code_r;
  reg         slaveS1_r;
  reg         slaveS2_r;
  wire        chopTick;
  wire        convOn;

  localparam integer SCLK_LAST_I = `CDC_EXTRA_SCLK - 1;
  localparam [2:0]   SCLK_LAST   = SCLK_LAST_I[2:0];

  cdc_chop_div u_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .run     (chop_r & convOn),
    .tick    (chopTick)
  );

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slaveS1_r <= 1'b0;
      slaveS2_r <= 1'b0;
    end else begin
      slaveS1_r <= slaveMode;
      slaveS2_r <= slaveS1_r;
    end
  end

  assign convOn = en_r & ~slaveS2_r;

  // New word waits for four serial clocks before it is applied.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r      <= 24'h000000;
      pendValid_r <= 1'b0;
      sclkCnt_r   <= 3'h0;
      chop_r      <= 1'b1;
      mode_r      <= 1'b0;
      int_r       <= 1'b0;
      en_r        <= 1'b0;
      code_r      <= 10'h000;
    end else if (regWrite && regAddr == `CDC_ADDR) begin
      pend_r      <= {10'h000, regWdata[13:0]};
      pendValid_r <= 1'b1;
      sclkCnt_r   <= 3'h0;
    end else if (pendValid_r && sclkEdge) begin
      if (sclkCnt_r == SCLK_LAST) begin
        pendValid_r <= 1'b0;
        chop_r      <= pend_r[`CDC_BIT_CHOP];
        mode_r      <= pend_r[`CDC_BIT_MODE];
        int_r       <= pend_r[`CDC_BIT_INT];
        en_r        <= pend_r[`CDC_BIT_EN];
        code_r      <= pend_r[`CDC_CODE_MSB:0];
      end else begin
        sclkCnt_r   <= sclkCnt_r + 3'h1;
      end
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata         <= `CDC_RESET;
      converterOn      <= 1'b0;
      converterCode    <= 10'h000;
      chopPhase        <= 1'b0;
      calPinConnect    <= 1'b0;
      channelAcquire   <= 1'b0;
      extSwitchOpen    <= 1'b0;
      internalRoute    <= 1'b0;
      acLeadOffDisable <= 1'b0;
    end else begin
      regRdata         <= {10'h000, chop_r, mode_r, int_r, en_r, code_r};
      converterOn      <= convOn;
      converterCode    <= code_r;
      if (!(chop_r && convOn))
        chopPhase      <= 1'b0;
      else if (chopTick)
        chopPhase      <= ~chopPhase;
      calPinConnect    <= mode_r | (convOn & ~mode_r);
      channelAcquire   <= mode_r;
      extSwitchOpen    <= mode_r & int_r;
      internalRoute    <= mode_r & int_r;
      acLeadOffDisable <= convOn;
    end
  end
endmodule

// ===== dv/cdc_chk_properties.sv
// Purpose: Port assertions for the converter control.
// Assumes: Outputs update on the same edge as regRdata.
// Notes:   Bound to the block by module name.
`timescale 1ns/100ps
module cdc_chk (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        slaveMode,
  input wire [23:0] regRdata,
  input wire        converterOn,
  input wire [9:0]  converterCode,
  input wire        calPinConnect,
  input wire        channelAcquire,
  input wire        internalRoute,
  input wire        acLeadOffDisable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire m = regRdata[12];
  code_match_a: assert property (converterCode == regRdata[9:0])
    else $error("code");
  mode_acq_a: assert property (channelAcquire == m) else $error("acq");
  int_route_a: assert property (internalRoute == (m & regRdata[11]))
    else $error("route");
  en_off_a: assert property (!regRdata[10] |-> !converterOn)
    else $error("en");
  pin_drive_a: assert property (calPinConnect == (m | converterOn))
    else $error("pin");
  slave_off_a: assert property (slaveMode [*4] |-> !converterOn)
    else $error("slave");
  lead_off_a: assert property (acLeadOffDisable == converterOn)
    else $error("lead");
  upper_zero_a: assert property (regRdata[23:14] == 0)
    else $error("upper");
  cover property (converterOn && !m);
  cover property (internalRoute);
  cover property (slaveMode && regRdata[10]);
endmodule
bind cdc_calibration_dac_control cdc_chk u_chk (.*);

// ===== dv/cdc_host.sv
// Purpose: Host model writing words over the register port.
// Assumes: A write strobe is followed by serial clock pulses.
// Notes:   Released lines show inverted values.
`timescale 1ns/100ps
module cdc_host (
  input  wire         ref_clk,
  output logic        regWrite,
  output logic [7:0]  regAddr,
  output logic [23:0] regWdata,
  output logic        sclkEdge
);
  initial {regWrite, regAddr, regWdata, sclkEdge} = '0;
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge ref_clk) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(posedge ref_clk) #1 {regWrite, sclkEdge} = 2'b01;
    {regAddr, regWdata} = ~{a, d};
    repeat (4) @(posedge ref_clk);
    #1 sclkEdge = 1'b0;
  endtask
endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for the converter control.
// Assumes: The host model performs each register write.
// Notes:   Each table row pairs a write with expected outputs.
`timescale 1ns/100ps
`include "cdc_regs.vh"
module tb;
  logic ref_clk, sys_rst, slaveMode, regWrite, sclkEdge, p, converterOn;
  logic chopPhase, calPinConnect, channelAcquire, extSwitchOpen;
  logic internalRoute, acLeadOffDisable;
  logic [7:0] regAddr;
  logic [9:0] converterCode;
  logic [23:0] regWdata, regRdata;
  int n_errors = 0, check_count = 0, i, n;
  logic [7:0] ad [5] = '{8'h09, 8'h0A, 8'h09, 8'h09, 8'h09};
  logic [23:0] wd [5] = '{24'hFFC5A5, 0, 24'h3C00, 24'h2800, 24'h400};
  logic [23:0] rd [5] = '{24'h5A5, 24'h5A5, 24'h3C00, 24'h2800, 24'h400};
  logic [5:0] ex [5] = '{6'h31, 6'h31, 6'h3F, 6'h0, 6'h0};
  wire [5:0] outs = {converterOn, calPinConnect, internalRoute,
                     channelAcquire, extSwitchOpen, acLeadOffDisable};
  cdc_calibration_dac_control dut (.*);
  cdc_host host (.*);
  task chk(input logic c);
    check_count++;
    if (!c) begin
      n_errors++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    sys_rst = 1;
    slaveMode = 0;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 0;
    chk(regRdata === `CDC_RESET && {converterOn, converterCode} === 0);
    for (i = 0; i < 5; i++) begin
      slaveMode = (i == 4);
      host.wr(ad[i], wd[i]);
      repeat (2) @(posedge ref_clk);
      #1 chk(regRdata === rd[i] && outs === ex[i]);
      chk(converterCode === rd[i][9:0]);
      if (!rd[i][13] || !ex[i][5]) chk(chopPhase === 1'b0);
    end
    slaveMode = 0;
    host.wr(8'h09, 24'h002400);
    p = chopPhase;
    n = 0;
    repeat (190) begin
      @(posedge ref_clk);
      #1 n += (chopPhase !== p);
      p = chopPhase;
    end
    chk(n >= 190 / `CDC_CHOP_HALF - 1 && n <= 190 / `CDC_CHOP_HALF + 1);
    end_sim;
  end
endmodule
